// >>> hw/spmc_ctrl.sv
/*
 * Stop-mode power controller: picks stop2 or stop3 on a STOP instruction,
 * drives the power and clock controls of each domain, screens serial debug
 * commands during stop and tracks wake-up and the stop2 pin latch.
 * Assumes stop_exec, rti_irq, adc_irq and the debug command strobe come from
 * logic on pclk; reset and wake pins and the detector trip are asynchronous.
 */
`timescale 1ns/1ps

module spmc_ctrl #(
	parameter int KBI_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spmc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic stop_exec,
	input wire logic bdm_go,
	input wire logic dbg_cmd_valid,
	input wire spmc_pkg::spmc_cmd_t dbg_cmd,
	output spmc_pkg::spmc_dbg_rsp_t dbg_rsp,
	input wire logic reset_pin_n,
	input wire logic irq_pin_n,
	input wire logic [KBI_W-1:0] kbi_pin_n,
	input wire logic lvd_trip,
	input wire logic rti_irq,
	input wire logic adc_irq,
	output spmc_pkg::spmc_pwr_t pwr,
	output spmc_pkg::spmc_state_t stop_state,
	output logic illegal_op_reset,
	output logic stop2_wake_por,
	output logic lvd_irq,
	output logic lvd_reset
);
	import spmc_pkg::*;

	if (KBI_W < 1 || KBI_W > KBI_MAX) begin : g_bad_kbi_w
		$error("KBI_W out of range");
	end

	function automatic logic in_stop(input spmc_state_t s);
		in_stop = (s == ST_STOP2) || (s == ST_STOP3);
	endfunction : in_stop

	// -------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------
	localparam int SYN_W = KBI_W + 3;
	logic [SYN_W-1:0] syn1_r;
	logic [SYN_W-1:0] syn2_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			syn1_r <= '1;
			syn2_r <= '1;
		end else begin
			syn1_r <= {~lvd_trip, reset_pin_n, irq_pin_n, kbi_pin_n};
			syn2_r <= syn1_r;
		end
	end

	wire logic [KBI_W-1:0] kbi_n_s = syn2_r[KBI_W-1:0];
	wire logic irq_low = ~syn2_r[KBI_W];
	wire logic rst_low = ~syn2_r[KBI_W+1];
	wire logic trip_s = ~syn2_r[KBI_W+2];

	// -------------------------------------------------------------------
	// Registers and APB slave
	// -------------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	spmc_state_t state_r;
	logic dbg_ent_r;
	logic held_r;
	logic recov_r;
	logic [WAKE_W-1:0] wake_r;
	logic trip_q_r;

	wire logic [ADDR_W-1:0] a_ctrl = ADDR_W'(OFS_CTRL);
	wire logic [ADDR_W-1:0] a_stat = ADDR_W'(OFS_STAT);
	wire logic [ADDR_W-1:0] a_ack = ADDR_W'(OFS_ACK);
	wire logic hit_ctrl = paddr == a_ctrl;
	wire logic hit_stat = paddr == a_stat;
	wire logic hit_ack = paddr == a_ack;
	wire logic hit = hit_ctrl | hit_stat | hit_ack;
	wire logic acc_first = psel & penable & ~pready_r;
	wire logic commit = psel & penable & pready_r;
	wire logic wr_ctrl = commit & pwrite & hit_ctrl;
	wire logic wr_ack = commit & pwrite & hit_ack & pwdata[AB_RELEASE];

	logic [31:0] stat_word;
	always_comb begin
		stat_word = '0;
		stat_word[SB_STATE_LSB +: 2] = state_r;
		stat_word[SB_HELD] = held_r;
		stat_word[SB_RECOV] = recov_r;
		stat_word[SB_DBG_ENT] = dbg_ent_r;
		stat_word[SB_WAKE_LSB +: WAKE_W] = wake_r;
	end

	wire logic [31:0] rd_data = hit_ctrl ? ctrl_r : (hit_stat ? stat_word : 32'h0000_0000);

	// Access phase lasts two cycles so the answer comes from flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= acc_first;
			prdata_r <= (acc_first && !pwrite) ? rd_data : 32'h0000_0000;
			pslverr_r <= acc_first & ~hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_r <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= pwdata & CTRL_WMASK;
	end

	// -------------------------------------------------------------------
	// Control decode
	// -------------------------------------------------------------------
	wire logic stop_en = ctrl_r[CB_STOP_EN];
	wire logic ppd_sel = ctrl_r[CB_PPD_SEL];
	wire logic dbg_en = ctrl_r[CB_DBG_EN];
	wire logic lvd_en = ctrl_r[CB_LVD_EN];
	wire logic lvd_armed = lvd_en & ctrl_r[CB_LVD_STOP];
	wire logic osc_stop = ctrl_r[CB_OSC_STOP];
	wire logic hi_range = ctrl_r[CB_HI_RANGE];
	wire logic wt_en = ctrl_r[CB_WT_EN];
	wire logic wt_ext = ctrl_r[CB_WT_CLKS];
	wire logic adc_async = ctrl_r[CB_ADC_ASYNC];
	wire logic [KBI_W-1:0] kbi_pe = ctrl_r[CB_KBI_LSB +: KBI_W];

	wire logic stop_req = (state_r == ST_RUN) & stop_exec;
	wire logic go_stop = stop_req & stop_en;
	wire logic go_illegal = stop_req & ~stop_en;
	wire logic pick_stop2 = ppd_sel & ~dbg_en & ~lvd_armed;

	// -------------------------------------------------------------------
	// Low-voltage detector events
	// -------------------------------------------------------------------
	wire logic trip_rise = trip_s & ~trip_q_r;
	wire logic lvd_live = lvd_en & (~in_stop(state_r) | lvd_armed);
	wire logic lvd_event = trip_rise & lvd_live;

	// -------------------------------------------------------------------
	// Wake decode
	// -------------------------------------------------------------------
	wire logic kbi_hit = |(kbi_pe & ~kbi_n_s);
	wire logic bkgd_hit = dbg_cmd_valid & (dbg_cmd == CMD_BACKGROUND) & dbg_ent_r;
	wire logic rti_live = rti_irq & wt_en;
	wire logic wake2 = rst_low | irq_low | rti_live;
	wire logic wake3 = wake2 | (lvd_event & ~ctrl_r[CB_LVD_RST]) | adc_irq | kbi_hit;

	wire logic [WAKE_W-1:0] cause = {bkgd_hit, kbi_hit, adc_irq, lvd_event, rti_live, irq_low,
		rst_low};

	// -------------------------------------------------------------------
	// Mode state machine
	// -------------------------------------------------------------------
	spmc_state_t state_nxt;
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RUN: begin
				if (go_stop)
					state_nxt = pick_stop2 ? ST_STOP2 : ST_STOP3;
			end
			ST_STOP2: begin
				if (wake2)
					state_nxt = ST_RUN;
			end
			ST_STOP3: begin
				if (bkgd_hit)
					state_nxt = ST_BDM;
				else if (wake3)
					state_nxt = ST_RUN;
			end
			ST_BDM: begin
				if (bdm_go)
					state_nxt = ST_RUN;
			end
		endcase
	end

	wire logic leave2 = (state_r == ST_STOP2) & (state_nxt == ST_RUN);
	wire logic leave3 = (state_r == ST_STOP3) & (state_nxt != ST_STOP3);
	wire logic held_nxt = go_stop | (held_r & ~leave3 & ~wr_ack);
	wire logic recov_nxt = leave2 | (recov_r & ~wr_ack);
	wire logic dbg_ent_nxt = go_stop ? dbg_en : (dbg_ent_r & (state_nxt != ST_RUN));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_RUN;
			dbg_ent_r <= 1'b0;
			held_r <= 1'b0;
			recov_r <= 1'b0;
			wake_r <= '0;
			trip_q_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			dbg_ent_r <= dbg_ent_nxt;
			held_r <= held_nxt;
			recov_r <= recov_nxt;
			trip_q_r <= trip_s;
			if (leave2 || leave3)
				wake_r <= cause;
		end
	end

	// -------------------------------------------------------------------
	// Power and clock controls for the next state
	// -------------------------------------------------------------------
	spmc_pwr_t pwr_nxt;
	always_comb begin
		pwr_nxt = '0;
		pwr_nxt.pins_held = held_nxt;
		unique case (state_nxt)
			ST_RUN, ST_BDM: begin
				pwr_nxt.periph_clk_en = 1'b1;
				pwr_nxt.debug_clk_en = 1'b1;
				pwr_nxt.cpu_on = 1'b1;
				pwr_nxt.flash_on = 1'b1;
				pwr_nxt.port_regs_on = 1'b1;
				pwr_nxt.reg_full = 1'b1;
				pwr_nxt.clkgen_on = 1'b1;
				pwr_nxt.adc_run = 1'b1;
				pwr_nxt.rti_run = wt_en;
				pwr_nxt.kbi_wake_en = 1'b1;
			end
			ST_STOP2: begin
				pwr_nxt.ram_standby = 1'b1;
				pwr_nxt.rti_run = wt_en & ~wt_ext;
			end
			ST_STOP3: begin
				pwr_nxt.ram_standby = 1'b1;
				pwr_nxt.debug_clk_en = dbg_ent_nxt;
				pwr_nxt.reg_full = dbg_ent_nxt | lvd_armed;
				pwr_nxt.clkgen_on = dbg_ent_nxt | (osc_stop & (~hi_range | lvd_armed));
				pwr_nxt.adc_run = adc_async & lvd_en;
				pwr_nxt.rti_run = wt_en & (~wt_ext | osc_stop);
				pwr_nxt.kbi_wake_en = |kbi_pe;
			end
		endcase
	end

	// -------------------------------------------------------------------
	// Debug command screening
	// -------------------------------------------------------------------
	wire logic stopped = in_stop(state_r);
	spmc_dbg_rsp_t rsp_nxt;
	always_comb begin
		rsp_nxt = '0;
		if (dbg_cmd_valid) begin
			if (!stopped) begin
				rsp_nxt.ack = 1'b1;
				rsp_nxt.mem_access = dbg_cmd != CMD_BACKGROUND;
			end else if (dbg_cmd == CMD_MEM_STATUS) begin
				rsp_nxt.ack = 1'b1;
				rsp_nxt.stop_err = 1'b1;
			end else if (bkgd_hit && state_r == ST_STOP3) begin
				rsp_nxt.ack = 1'b1;
			end else begin
				rsp_nxt.refuse = 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------
	// Output flip-flops
	// -------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr <= '{periph_clk_en: 1'b1, debug_clk_en: 1'b1, cpu_on: 1'b1, flash_on: 1'b1,
				port_regs_on: 1'b1, ram_standby: 1'b0, reg_full: 1'b1, clkgen_on: 1'b1,
				adc_run: 1'b1, rti_run: 1'b0, kbi_wake_en: 1'b1, pins_held: 1'b0};
			dbg_rsp <= '0;
			illegal_op_reset <= 1'b0;
			stop2_wake_por <= 1'b0;
			lvd_irq <= 1'b0;
			lvd_reset <= 1'b0;
		end else begin
			pwr <= pwr_nxt;
			dbg_rsp <= rsp_nxt;
			illegal_op_reset <= go_illegal;
			stop2_wake_por <= leave2;
			lvd_irq <= lvd_event & ~ctrl_r[CB_LVD_RST];
			lvd_reset <= lvd_event & ctrl_r[CB_LVD_RST];
		end
	end

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign stop_state = state_r;

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_dbg_clk;
		in_stop(state_r) && dbg_ent_r |-> pwr.debug_clk_en;
	endproperty
	a_dbg_clk: assert property (p_dbg_clk) else $error("debug clock off in stop");

	property p_dbg_reg;
		(state_r == ST_STOP3) && dbg_ent_r |-> pwr.reg_full && pwr.clkgen_on && !pwr.cpu_on;
	endproperty
	a_dbg_reg: assert property (p_dbg_reg) else $error("debug stop3 power wrong");

	property p_dbg_no_stop2;
		stop_req && stop_en && ppd_sel && dbg_en |=> stop_state == ST_STOP3;
	endproperty
	a_dbg_no_stop2: assert property (p_dbg_no_stop2) else $error("stop2 with debug");

	property p_refuse;
		dbg_cmd_valid && stopped && dbg_cmd == CMD_OTHER |=> dbg_rsp.refuse && !dbg_rsp.ack;
	endproperty
	a_refuse: assert property (p_refuse) else $error("command not refused in stop");

	property p_status_err;
		dbg_cmd_valid && stopped && dbg_cmd == CMD_MEM_STATUS
			|=> dbg_rsp.ack && dbg_rsp.stop_err && !dbg_rsp.mem_access;
	endproperty
	a_status_err: assert property (p_status_err) else $error("status access wrong");

	property p_bkgd_wake;
		state_r == ST_STOP3 && bkgd_hit |=> stop_state == ST_BDM ##1 stop_state != ST_STOP3;
	endproperty
	a_bkgd_wake: assert property (p_bkgd_wake) else $error("background wake missed");

	property p_bdm_all;
		state_r == ST_BDM && dbg_cmd_valid |=> dbg_rsp.ack;
	endproperty
	a_bdm_all: assert property (p_bdm_all) else $error("command refused in debug");

	property p_lvd_stop3;
		stop_req && stop_en && lvd_armed |=> stop_state == ST_STOP3 && pwr.reg_full;
	endproperty
	a_lvd_stop3: assert property (p_lvd_stop3) else $error("armed detector stop wrong");

	property p_periph_off;
		in_stop(stop_state) |-> !pwr.periph_clk_en;
	endproperty
	a_periph_off: assert property (p_periph_off) else $error("peripheral clock in stop");

	property p_stop2_off;
		stop_state == ST_STOP2 |-> !pwr.cpu_on && !pwr.flash_on && !pwr.reg_full && pwr.pins_held;
	endproperty
	a_stop2_off: assert property (p_stop2_off) else $error("stop2 domains on");

	property p_illegal;
		stop_req && !stop_en |=> illegal_op_reset && stop_state == ST_RUN;
	endproperty
	a_illegal: assert property (p_illegal) else $error("disabled stop not trapped");

	property p_stop2_hold;
		state_r == ST_STOP2 && !wake2 |=> stop_state == ST_STOP2 && $stable(pwr);
	endproperty
	a_stop2_hold: assert property (p_stop2_hold) else $error("stop2 left without wake");

	c_stop2: cover property (stop_req && stop_en && pick_stop2 ##1 stop_state == ST_STOP2);
	c_stop3_kbi: cover property (state_r == ST_STOP3 && kbi_hit ##1 stop_state == ST_RUN);
	c_bkgd: cover property (state_r == ST_STOP3 && bkgd_hit ##1 stop_state == ST_BDM);
	c_stop2_por: cover property (stop2_wake_por ##[1:20] wr_ack);

endmodule : spmc_ctrl

// >>> hw/spmc_pkg.sv
/*
 * Shared constants and types of the stop-mode power controller: APB register
 * offsets, field positions, reset values, state and command enumerations and
 * the packed control and debug-answer bundles.
 * Assumes a 32-bit APB with byte addresses and a core on the same clock.
 */
package spmc_pkg;

	// -------------------------------------------------------------------
	// Register offsets (byte addresses)
	// -------------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_ACK = 8'h08;

	// -------------------------------------------------------------------
	// Control register fields
	// -------------------------------------------------------------------
	localparam int CB_STOP_EN = 0;
	localparam int CB_PPD_SEL = 1;
	localparam int CB_DBG_EN = 2;
	localparam int CB_LVD_EN = 3;
	localparam int CB_LVD_STOP = 4;
	localparam int CB_LVD_RST = 5;
	localparam int CB_OSC_STOP = 6;
	localparam int CB_HI_RANGE = 7;
	localparam int CB_WT_EN = 8;
	localparam int CB_WT_CLKS = 9;
	localparam int CB_ADC_ASYNC = 10;
	localparam int CB_KBI_LSB = 16;
	localparam int KBI_MAX = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h00ff_07ff;

	// -------------------------------------------------------------------
	// Status register fields and acknowledge register
	// -------------------------------------------------------------------
	localparam int SB_STATE_LSB = 0;
	localparam int SB_HELD = 4;
	localparam int SB_RECOV = 5;
	localparam int SB_DBG_ENT = 6;
	localparam int SB_WAKE_LSB = 8;
	localparam int WAKE_W = 7;
	localparam int AB_RELEASE = 0;

	// Wake cause bits
	localparam int WK_RESET = 0;
	localparam int WK_IRQ = 1;
	localparam int WK_RTI = 2;
	localparam int WK_LVD = 3;
	localparam int WK_ADC = 4;
	localparam int WK_KBI = 5;
	localparam int WK_BKGD = 6;

	// -------------------------------------------------------------------
	// Types
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {ST_RUN, ST_STOP3, ST_STOP2, ST_BDM} spmc_state_t;

	typedef enum logic [1:0] {CMD_BACKGROUND, CMD_MEM_STATUS, CMD_OTHER} spmc_cmd_t;

	typedef struct packed {
		logic periph_clk_en;
		logic debug_clk_en;
		logic cpu_on;
		logic flash_on;
		logic port_regs_on;
		logic ram_standby;
		logic reg_full;
		logic clkgen_on;
		logic adc_run;
		logic rti_run;
		logic kbi_wake_en;
		logic pins_held;
	} spmc_pwr_t;

	typedef struct packed {
		logic ack;
		logic refuse;
		logic stop_err;
		logic mem_access;
	} spmc_dbg_rsp_t;

endpackage : spmc_pkg

// >>> tb/spmc_core_model.sv
/*
 * Behavioural model of the processor core and the serial debug controller
 * that sit on the far side of the stop-mode power controller.
 * Assumes one pclk domain; every strobe is a one-cycle pulse after an edge.
 */
`timescale 1ns/1ps

module spmc_core_model (
	input wire logic pclk,
	output logic stop_exec,
	output logic bdm_go,
	output logic dbg_cmd_valid,
	output spmc_pkg::spmc_cmd_t dbg_cmd
);
	import spmc_pkg::*;

	initial begin
		stop_exec = 1'b0;
		bdm_go = 1'b0;
		dbg_cmd_valid = 1'b0;
		dbg_cmd = CMD_OTHER;
	end

	task stop_op();
		@(posedge pclk);
		stop_exec <= 1'b1;
		@(posedge pclk);
		stop_exec <= 1'b0;
	endtask : stop_op

	// Host side of the serial link: one command per pulse
	task send(input spmc_cmd_t c);
		@(posedge pclk);
		dbg_cmd_valid <= 1'b1;
		dbg_cmd <= c;
		@(posedge pclk);
		dbg_cmd_valid <= 1'b0;
	endtask : send

	task go();
		@(posedge pclk);
		bdm_go <= 1'b1;
		@(posedge pclk);
		bdm_go <= 1'b0;
	endtask : go

endmodule : spmc_core_model

// >>> tb/spmc_ctrl_tb.sv
/*
 * Self-checking bench of the stop-mode power controller: APB accesses and
 * debug answers are queued by the driver and compared by a monitor.
 * Assumes the core model in spmc_core_model.sv and a 200 MHz pclk.
 */
`timescale 1ns/1ps

module spmc_ctrl_tb;
	import spmc_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic stop_exec, bdm_go, dbg_cmd_valid, reset_pin_n, irq_pin_n;
	logic lvd_trip, rti_irq, adc_irq, illegal_op_reset, stop2_wake_por, lvd_irq, lvd_reset;
	logic [7:0] kbi_pin_n;
	spmc_cmd_t dbg_cmd;
	spmc_dbg_rsp_t dbg_rsp;
	spmc_pwr_t pwr;
	spmc_state_t stop_state;
	logic [32:0] apb_q[$];
	logic [3:0] dbg_q[$];
	logic [32:0] mx;
	int n_errors = 0;
	int num_checks = 0;
	int seed = 32'h88f0f1f9;
	int n;

	spmc_ctrl #(.KBI_W(8)) spmc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .stop_exec, .bdm_go, .dbg_cmd_valid, .dbg_cmd,
		.dbg_rsp, .reset_pin_n, .irq_pin_n, .kbi_pin_n, .lvd_trip, .rti_irq, .adc_irq, .pwr,
		.stop_state, .illegal_op_reset, .stop2_wake_por, .lvd_irq, .lvd_reset);

	spmc_core_model spmc_core_model_i (.pclk, .stop_exec, .bdm_go, .dbg_cmd_valid, .dbg_cmd);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int k;
		apb_q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t ns: bus hang", $time);
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task cmd(input spmc_cmd_t c, input logic [3:0] e);
		dbg_q.push_back(e);
		spmc_core_model_i.send(c);
	endtask : cmd

	task wait_st(input spmc_state_t s);
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			#1;
			if (stop_state === s) break;
		end
		chk(32'(stop_state), 32'(s), "state");
	endtask : wait_st

	// ----------------------------------------------------------------
	// Monitor and stimulus
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			mx = apb_q.pop_front();
			chk(32'(pslverr), 32'(mx[32]), "bus error");
			if (!pwrite) chk(prdata, mx[31:0], "read data");
		end
		if (presetn && dbg_rsp !== 4'h0) chk(32'(dbg_rsp), 32'(dbg_q.pop_front()), "debug answer");
	end

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		reset_pin_n = 1'b1;
		irq_pin_n = 1'b1;
		kbi_pin_n = 8'hff;
		lvd_trip = 1'b0;
		rti_irq = 1'b0;
		adc_irq = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0, {1'b0, CTRL_RST});
		rnd = $random(seed);
		apb(1'b1, OFS_CTRL, rnd, 33'h0);
		apb(1'b0, OFS_CTRL, 32'h0, {1'b0, rnd & CTRL_WMASK});
		apb(1'b1, OFS_STAT, rnd, 33'h0);
		apb(1'b0, OFS_STAT, 32'h0, 33'h0);
		apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
		apb(1'b1, OFS_CTRL, 32'h0, 33'h0);
		for (int i = 0; i < 4; i++) begin
			rnd = $random(seed);
			cmd(rnd[0] ? CMD_OTHER : CMD_MEM_STATUS, 4'h9);
		end
		$display("test registers done");
		spmc_core_model_i.stop_op();
		#1;
		chk(32'(illegal_op_reset), 32'h1, "illegal op");
		chk(32'(stop_state), 32'(ST_RUN), "no stop");
		$display("test stop disabled done");
		apb(1'b1, OFS_CTRL, 32'h0000_0103, 33'h0);
		spmc_core_model_i.stop_op();
		#1;
		chk(32'(stop_state), 32'(ST_STOP2), "stop2");
		chk(32'(pwr & 12'hfe5), 32'h045, "stop2 power");
		cmd(CMD_OTHER, 4'h4);
		cmd(CMD_BACKGROUND, 4'h4);
		@(posedge pclk);
		irq_pin_n <= 1'b0;
		wait_st(ST_RUN);
		chk(32'(stop2_wake_por), 32'h1, "stop2 restart");
		apb(1'b0, OFS_STAT, 32'h0, {1'b0, 32'h0000_0230});
		irq_pin_n <= 1'b1;
		apb(1'b1, OFS_ACK, 32'h1, 33'h0);
		apb(1'b0, OFS_STAT, 32'h0, {1'b0, 32'h0000_0200});
		$display("test stop2 done");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, OFS_CTRL, i ? 32'h0001_00db : 32'h0000_0007, 33'h0);
			spmc_core_model_i.stop_op();
			#1;
			chk(32'(stop_state), 32'(ST_STOP3), "override");
			chk(32'(pwr & 12'hc73), i ? 32'h073 : 32'h471, "stop3 power");
			cmd(CMD_MEM_STATUS, 4'ha);
			cmd(CMD_OTHER, 4'h4);
			cmd(CMD_BACKGROUND, i ? 4'h4 : 4'h8);
			if (i == 0) begin
				wait_st(ST_BDM);
				cmd(CMD_OTHER, 4'h9);
				spmc_core_model_i.go();
				wait_st(ST_RUN);
			end else begin
				@(posedge pclk);
				kbi_pin_n[0] <= 1'b0;
				wait_st(ST_RUN);
				@(posedge pclk);
				kbi_pin_n[0] <= 1'b1;
			end
		end
		$display("test stop3 overrides done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_CTRL, (i == 1) ? 32'h0000_07c9 : 32'h0000_0101, 33'h0);
			spmc_core_model_i.stop_op();
			#1;
			chk(32'(stop_state), 32'(ST_STOP3), "stop3");
			chk(32'(pwr.rti_run), 32'h1, "timer runs");
			chk(32'(pwr), (i == 1) ? 32'h04d : 32'h045, "stop3 options");
			@(posedge pclk);
			rti_irq <= (i == 0);
			adc_irq <= (i == 1);
			reset_pin_n <= (i != 2);
			wait_st(ST_RUN);
			@(posedge pclk);
			rti_irq <= 1'b0;
			adc_irq <= 1'b0;
			reset_pin_n <= 1'b1;
		end
		$display("test stop3 wake done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_CTRL, (i == 1) ? 32'h0000_0029 :
				((i == 2) ? 32'h0000_0019 : 32'h0000_0009), 33'h0);
			if (i == 2)
				spmc_core_model_i.stop_op();
			lvd_trip <= 1'b1;
			for (n = 0; n < 20 && !(lvd_irq || lvd_reset); n++) begin
				@(posedge pclk);
				#1;
			end
			chk(32'({lvd_reset, lvd_irq}), (i == 1) ? 32'h2 : 32'h1, "detector");
			chk(32'(stop_state), 32'(ST_RUN), "detector wake");
			@(posedge pclk);
			lvd_trip <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		$display("test detector done");
		chk(32'(apb_q.size() + dbg_q.size()), 32'h0, "answers missing");
		end_sim();
	end

endmodule : spmc_ctrl_tb
